// [interlock_defines.svh]
// Constants for the interlock supervisor: register map, fields and timing.
`ifndef INTERLOCK_DEFINES_SVH
`define INTERLOCK_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define REG_CTRL_ADDR 4'h0
`define REG_STATUS_ADDR 4'h4
`define REG_FAULT_ADDR 4'h8
`define CTRL_RESET 1'h0
`define CTRL_PWR_LOCK_BIT 0
`define ST_STATE_LSB 0
`define ST_WARN_BIT 2
`define ST_FAIL_BIT 3
`define ST_DIAG_BIT 4
`define FLT_LIVE_LSB 0
`define FLT_FAIL_LSB 4

// ----------------------------------------------------------------
// Red flash codes
// ----------------------------------------------------------------
`define CODE_NONE 3'h0
`define CODE_CLOSED_A 3'h1
`define CODE_CLOSED_B 3'h2
`define CODE_XWIRE 3'h3
`define CODE_TEMP 3'h4
`define CODE_ACT_BAD 3'h5
`define CODE_TGT_BAD 3'h6
`define CODE_STEADY 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS 8
`define TICK_PERIOD_NS 1000000
`define MS_PER_MIN 60000
`define WARN_DELAY_MIN 30
`define FB_SETTLE_NS 1000
`define YEL_FLASH_HZ 3
`define FLASH_ON_MS 11'h0c8
`define FLASH_OFF_MS 11'h0c8
`define FLASH_PAUSE_MS 11'h03e8

// ----------------------------------------------------------------
// Pin vector positions after synchronisation
// ----------------------------------------------------------------
`define PIN_COUNT 11
`define PIN_ACT 0
`define PIN_MARGIN 1
`define PIN_LTGT 2
`define PIN_SOL 3
`define PIN_FB_A 4
`define PIN_FB_B 5
`define PIN_XWIRE 6
`define PIN_TEMP 7
`define PIN_ACT_BAD 8
`define PIN_TGT_BAD 9
`define PIN_INT_ERR 10

`endif

// [interlock_pkg.sv]
// Types shared by the interlock supervisor modules.
package interlock_pkg;

	typedef enum logic [1:0] {
		ST_OPEN = 2'h0,
		ST_CLOSED = 2'h1,
		ST_LOCKED = 2'h3,
		ST_FAIL = 2'h2
	} guard_state_t;

	typedef enum logic [1:0] {
		PH_ON = 2'h0,
		PH_OFF = 2'h1,
		PH_PAUSE = 2'h3
	} flash_phase_t;

endpackage

// [pin_sync.sv]
// Two-flop synchroniser for a vector of asynchronous pin levels.
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			level <= '0;
		end else begin
			meta_reg <= pin;
			level <= meta_reg;
		end
	end

endmodule

// [flash_code_gen.sv]
// Red LED pulse-count generator: bursts of N pulses, then a long pause.
`include "interlock_defines.svh"
module flash_code_gen (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic [2:0] code,
	output logic red
);

	interlock_pkg::flash_phase_t phase_reg;
	logic [10:0] cnt_reg;
	logic [2:0] idx_reg;
	wire logic expired = tick && (cnt_reg == 11'h000);
	wire logic last_pulse = (idx_reg == code - 3'h1);

	// Idle parks in an expired pause, so a new code starts with a lit pulse
	// and its very first burst already carries the full pulse count.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= interlock_pkg::PH_PAUSE;
			cnt_reg <= 11'h000;
			idx_reg <= 3'h0;
			red <= 1'b0;
		end else if (code == `CODE_NONE) begin
			phase_reg <= interlock_pkg::PH_PAUSE;
			cnt_reg <= 11'h000;
			idx_reg <= 3'h0;
			red <= 1'b0;
		end else if (code == `CODE_STEADY) begin
			red <= 1'b1;
		end else if (tick && !expired) begin
			cnt_reg <= cnt_reg - 11'h001;
		end else if (expired) begin
			unique case (phase_reg)
				interlock_pkg::PH_ON: begin
					red <= 1'b0;
					cnt_reg <= `FLASH_OFF_MS - 11'h001;
					phase_reg <= interlock_pkg::PH_OFF;
				end
				interlock_pkg::PH_OFF: begin
					if (last_pulse) begin
						idx_reg <= 3'h0;
						cnt_reg <= `FLASH_PAUSE_MS - 11'h001;
						phase_reg <= interlock_pkg::PH_PAUSE;
					end else begin
						idx_reg <= idx_reg + 3'h1;
						red <= 1'b1;
						cnt_reg <= `FLASH_ON_MS - 11'h001;
						phase_reg <= interlock_pkg::PH_ON;
					end
				end
				interlock_pkg::PH_PAUSE: begin
					red <= 1'b1;
					cnt_reg <= `FLASH_ON_MS - 11'h001;
					phase_reg <= interlock_pkg::PH_ON;
				end
				default: begin
					phase_reg <= interlock_pkg::PH_ON;
				end
			endcase
		end
	end

endmodule

// [interlock_diag_supervisor.sv]
// Guard interlock supervisor: enabling paths, fault classes, LEDs and register slave.
`include "interlock_defines.svh"

module interlock_diag_supervisor #(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `MCLK_PERIOD_NS,
	parameter int WARN_TICKS = `WARN_DELAY_MIN * `MS_PER_MIN
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic ACT_DET,
	input wire logic ACT_MARGIN,
	input wire logic LOCK_TGT,
	input wire logic SOL_IN,
	input wire logic FB_CLOSED_A,
	input wire logic FB_CLOSED_B,
	input wire logic XWIRE_DET,
	input wire logic TEMP_HIGH,
	input wire logic ACT_BAD,
	input wire logic TGT_COMB_BAD,
	input wire logic INT_ERR,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic CLOSED_OUT_A,
	output logic CLOSED_OUT_B,
	output logic LOCKED_OUT_A,
	output logic LOCKED_OUT_B,
	output logic DIAG_OUT,
	output logic LED_GREEN,
	output logic LED_RED,
	output logic LED_YELLOW
);

	// ----------------------------------------------------------------
	// Derived timing
	// ----------------------------------------------------------------
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int WW = $clog2(WARN_TICKS + 1);
	localparam int SETTLE_CYCLES = `FB_SETTLE_NS / `MCLK_PERIOD_NS;
	localparam int YEL_HALF_TICKS = `TICK_PERIOD_NS / (`YEL_FLASH_HZ * 2 * 1000000) == 0 ?
		1000 / (`YEL_FLASH_HZ * 2) : 1;

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [`PIN_COUNT-1:0] pins;
	pin_sync #(
		.WIDTH(`PIN_COUNT)
	) pin_sync_inst (
		.clk(MCLK),
		.rst_b(RST_B),
		.pin({INT_ERR, TGT_COMB_BAD, ACT_BAD, TEMP_HIGH, XWIRE_DET, FB_CLOSED_B,
			FB_CLOSED_A, SOL_IN, LOCK_TGT, ACT_MARGIN, ACT_DET}),
		.level(pins)
	);

	wire logic act = pins[`PIN_ACT];
	wire logic margin = pins[`PIN_MARGIN];
	wire logic ltgt = pins[`PIN_LTGT];
	wire logic sol = pins[`PIN_SOL];

	// ----------------------------------------------------------------
	// Prescaler: one-cycle millisecond tick
	// ----------------------------------------------------------------
	logic [TW-1:0] tick_cnt_reg;
	logic tick_reg;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (tick_cnt_reg == TW'(TICK_CYCLES - 1));
			tick_cnt_reg <= (tick_cnt_reg == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic pwr_lock_reg;
	interlock_pkg::guard_state_t state_reg;
	interlock_pkg::guard_state_t state_next;
	logic [2:0] fail_code_reg;
	logic [2:0] fail_code_next;

	// Locking condition from the solenoid input, per variant.
	wire logic lock_cond = pwr_lock_reg ? sol : ~sol;

	// ----------------------------------------------------------------
	// Output feedback check
	// ----------------------------------------------------------------
	// Feedback is compared only once the closed pair has been steady for a
	// settling time, so the pin delay after a switch is not seen as a fault.
	// The edge comparison also blocks the one cycle in which the pair has
	// just switched and the counter has not yet been cleared.
	logic [7:0] settle_reg;
	logic closed_prev_reg;
	wire logic settled = (settle_reg == 8'(SETTLE_CYCLES)) && (closed_prev_reg == CLOSED_OUT_A);
	wire logic fb_a_err = settled && (pins[`PIN_FB_A] != CLOSED_OUT_A);
	wire logic fb_b_err = settled && (pins[`PIN_FB_B] != CLOSED_OUT_B);

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			settle_reg <= 8'h00;
			closed_prev_reg <= 1'b0;
		end else begin
			closed_prev_reg <= CLOSED_OUT_A;
			if (closed_prev_reg != CLOSED_OUT_A) begin
				settle_reg <= 8'h00;
			end else if (!settled) begin
				settle_reg <= settle_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fault classification
	// ----------------------------------------------------------------
	wire logic both_err = (fb_a_err && fb_b_err) || pins[`PIN_XWIRE];
	wire logic [2:0] warn_code =
		both_err ? `CODE_XWIRE :
		fb_a_err ? `CODE_CLOSED_A :
		fb_b_err ? `CODE_CLOSED_B :
		pins[`PIN_TEMP] ? `CODE_TEMP :
		`CODE_NONE;
	wire logic [2:0] hard_code =
		pins[`PIN_INT_ERR] ? `CODE_STEADY :
		pins[`PIN_TGT_BAD] ? `CODE_TGT_BAD :
		pins[`PIN_ACT_BAD] ? `CODE_ACT_BAD :
		`CODE_NONE;
	// A warning is live only while its cause is present.
	wire logic warn_live = (warn_code != `CODE_NONE);
	wire logic hard_live = (hard_code != `CODE_NONE);
	wire logic any_fault = warn_live || hard_live;

	// ----------------------------------------------------------------
	// Warning delay
	// ----------------------------------------------------------------
	logic [WW-1:0] warn_cnt_reg;
	wire logic warn_expired = (warn_cnt_reg == WW'(WARN_TICKS));

	// Counting restarts whenever the cause goes away, so each new warning
	// receives the full controlled-shutdown window.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			warn_cnt_reg <= '0;
		end else if (!warn_live || state_reg == interlock_pkg::ST_FAIL) begin
			warn_cnt_reg <= '0;
		end else if (tick_reg && !warn_expired) begin
			warn_cnt_reg <= warn_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Guard state machine
	// ----------------------------------------------------------------
	wire logic lock_ok = act && ltgt && lock_cond;

	always_comb begin
		state_next = state_reg;
		fail_code_next = fail_code_reg;
		unique case (state_reg)
			interlock_pkg::ST_OPEN: begin
				if (hard_live) begin
					state_next = interlock_pkg::ST_FAIL;
				end else if (act) begin
					state_next = interlock_pkg::ST_CLOSED;
				end
			end
			interlock_pkg::ST_CLOSED, interlock_pkg::ST_LOCKED: begin
				if (hard_live) begin
					state_next = interlock_pkg::ST_FAIL;
				end else if (warn_expired) begin
					state_next = interlock_pkg::ST_FAIL;
				end else if (!act) begin
					state_next = interlock_pkg::ST_OPEN;
				end else if (lock_ok) begin
					state_next = interlock_pkg::ST_LOCKED;
				end else begin
					state_next = interlock_pkg::ST_CLOSED;
				end
			end
			interlock_pkg::ST_FAIL: begin
				// Leaving needs the cause gone and the guard opened; the
				// close that follows then walks through the normal states.
				if (!any_fault && !act) begin
					state_next = interlock_pkg::ST_OPEN;
				end
			end
		endcase
		if (state_next == interlock_pkg::ST_FAIL && state_reg != interlock_pkg::ST_FAIL) begin
			fail_code_next = hard_live ? hard_code : warn_code;
		end else if (state_next != interlock_pkg::ST_FAIL) begin
			fail_code_next = `CODE_NONE;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= interlock_pkg::ST_OPEN;
			fail_code_reg <= `CODE_NONE;
		end else begin
			state_reg <= state_next;
			fail_code_reg <= fail_code_next;
		end
	end

	// ----------------------------------------------------------------
	// Safety and diagnostic outputs
	// ----------------------------------------------------------------
	wire logic failed = (state_next == interlock_pkg::ST_FAIL);
	wire logic closed_on = act && !failed;
	wire logic locked_on = lock_ok && !failed;
	wire logic diag_on = (state_next == interlock_pkg::ST_LOCKED) && !warn_live;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			CLOSED_OUT_A <= 1'b0;
			CLOSED_OUT_B <= 1'b0;
			LOCKED_OUT_A <= 1'b0;
			LOCKED_OUT_B <= 1'b1;
			DIAG_OUT <= 1'b0;
		end else begin
			CLOSED_OUT_A <= closed_on;
			CLOSED_OUT_B <= closed_on;
			LOCKED_OUT_A <= locked_on;
			LOCKED_OUT_B <= ~locked_on;
			DIAG_OUT <= diag_on;
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	logic [9:0] yel_cnt_reg;
	logic yel_blink_reg;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			yel_cnt_reg <= 10'h000;
			yel_blink_reg <= 1'b0;
		end else if (tick_reg) begin
			if (yel_cnt_reg == 10'(YEL_HALF_TICKS - 1)) begin
				yel_cnt_reg <= 10'h000;
				yel_blink_reg <= ~yel_blink_reg;
			end else begin
				yel_cnt_reg <= yel_cnt_reg + 10'h001;
			end
		end
	end

	wire logic yel_on =
		(state_reg == interlock_pkg::ST_LOCKED) ? (margin ? yel_blink_reg : 1'b1) :
		(state_reg == interlock_pkg::ST_CLOSED) ? yel_blink_reg :
		1'b0;

	// A latched failure shows its own code; otherwise a live warning shows.
	wire logic [2:0] red_code = (state_reg == interlock_pkg::ST_FAIL) ? fail_code_reg :
		warn_code;
	logic red_level;

	flash_code_gen flash_code_gen_inst (
		.clk(MCLK),
		.rst_b(RST_B),
		.tick(tick_reg),
		.code(red_code),
		.red(red_level)
	);

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			LED_GREEN <= 1'b0;
			LED_RED <= 1'b0;
			LED_YELLOW <= 1'b0;
		end else begin
			LED_GREEN <= 1'b1;
			LED_RED <= red_level;
			LED_YELLOW <= yel_on;
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	// Every access takes a fixed two edges: waitrequest drops for exactly one
	// cycle, and read data is loaded at the edge where it drops.
	wire logic req = AVS_READ || AVS_WRITE;
	wire logic accept = req && !AVS_WAITREQUEST;
	wire logic hit_ctrl = (AVS_ADDRESS == `REG_CTRL_ADDR);
	wire logic hit_status = (AVS_ADDRESS == `REG_STATUS_ADDR);
	wire logic hit_fault = (AVS_ADDRESS == `REG_FAULT_ADDR);
	wire logic [31:0] status_word = 32'({DIAG_OUT, state_reg == interlock_pkg::ST_FAIL,
		warn_live, state_reg});
	wire logic [31:0] fault_word = 32'({fail_code_reg, 1'b0, hard_live ? hard_code : warn_code});
	wire logic [31:0] read_mux =
		hit_ctrl ? 32'(pwr_lock_reg) :
		hit_status ? status_word :
		hit_fault ? fault_word :
		32'h0000_0000;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
		end else if (req && AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA <= AVS_READ ? read_mux : 32'h0000_0000;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			pwr_lock_reg <= `CTRL_RESET;
		end else if (accept && AVS_WRITE && hit_ctrl && AVS_BYTEENABLE[0]) begin
			pwr_lock_reg <= AVS_WRITEDATA[`CTRL_PWR_LOCK_BIT];
		end
	end

endmodule

// [interlock_diag_supervisor_sva.sv]
// Concurrent checks on the interlock supervisor ports.
`include "interlock_defines.svh"
module interlock_diag_supervisor_sva #(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `MCLK_PERIOD_NS,
	parameter int WARN_TICKS = `WARN_DELAY_MIN * `MS_PER_MIN
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic ACT_DET,
	input wire logic LOCK_TGT,
	input wire logic TEMP_HIGH,
	input wire logic ACT_BAD,
	input wire logic INT_ERR,
	input wire logic AVS_READ,
	input wire logic AVS_WAITREQUEST,
	input wire logic CLOSED_OUT_A,
	input wire logic CLOSED_OUT_B,
	input wire logic LOCKED_OUT_A,
	input wire logic LOCKED_OUT_B,
	input wire logic DIAG_OUT,
	input wire logic LED_GREEN,
	input wire logic LED_RED
);
	timeunit 1ns;
	timeprecision 1ps;
	// The warning timer may start up to one tick late, and sync and output stages add more.
	// Wide arithmetic: the full half-hour window in clock cycles exceeds 32 bits.
	localparam longint WARN_LIM = (longint'(WARN_TICKS) + 2) * TICK_CYCLES + 8;
	longint warn_cnt_reg;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			warn_cnt_reg <= 0;
		end else if (!TEMP_HIGH) begin
			warn_cnt_reg <= 0;
		end else if (warn_cnt_reg < WARN_LIM) begin
			warn_cnt_reg <= warn_cnt_reg + 1;
		end
	end
	sequence warn_start;
		$rose(TEMP_HIGH) && CLOSED_OUT_A;
	endsequence
	sequence bus_answer;
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence
	green_ready_a: assert property (RST_B && $past(RST_B) |-> LED_GREEN)
		else $error("green not lit");
	closed_cause_a: assert property ($rose(CLOSED_OUT_A) |-> $rose(CLOSED_OUT_B) && $past(ACT_DET, 3))
		else $error("closed pair without actuator");
	act_drop_a: assert property ($fell(ACT_DET) |-> ##[2:5] !(CLOSED_OUT_A || CLOSED_OUT_B))
		else $error("closed pair stays on");
	locked_cause_a: assert property ($rose(LOCKED_OUT_A) |-> $past(ACT_DET, 3) && $past(LOCK_TGT, 3))
		else $error("locked pair without cause");
	locked_compl_a: assert property (LOCKED_OUT_B == !LOCKED_OUT_A)
		else $error("locked pair not complementary");
	diag_cond_a: assert property (DIAG_OUT |-> CLOSED_OUT_A && LOCKED_OUT_A)
		else $error("diagnostic output while not locked");
	warn_diag_a: assert property ($rose(TEMP_HIGH) |-> ##[2:6] !DIAG_OUT)
		else $error("diagnostic output during warning");
	hard_fault_a: assert property ($rose(ACT_BAD) |-> ##[2:5] !(CLOSED_OUT_A || LOCKED_OUT_A || DIAG_OUT))
		else $error("outputs on after bad actuator");
	int_error_a: assert property (INT_ERR [*8] |-> LED_RED && !CLOSED_OUT_A && !LOCKED_OUT_A)
		else $error("internal error not handled");
	warn_hold_a: assert property (warn_start |-> CLOSED_OUT_A [*8])
		else $error("outputs dropped at warning start");
	warn_expire_a: assert property (warn_cnt_reg == WARN_LIM |-> !CLOSED_OUT_A && !DIAG_OUT)
		else $error("warning did not switch off");
	bus_wait_a: assert property ($rose(AVS_READ) |-> bus_answer)
		else $error("read not answered in time");
	bus_release_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
endmodule

bind interlock_diag_supervisor interlock_diag_supervisor_sva #(
	.TICK_CYCLES(TICK_CYCLES),
	.WARN_TICKS(WARN_TICKS)
) interlock_diag_supervisor_sva_inst (
	.MCLK, .RST_B, .ACT_DET, .LOCK_TGT, .TEMP_HIGH, .ACT_BAD, .INT_ERR, .AVS_READ,
	.AVS_WAITREQUEST, .CLOSED_OUT_A, .CLOSED_OUT_B, .LOCKED_OUT_A, .LOCKED_OUT_B,
	.DIAG_OUT, .LED_GREEN, .LED_RED
);

// [plc_side_model.sv]
// Machine-side model: solenoid command and read-back of the closed outputs.
module plc_side_model (
	input wire logic pwr_lock,
	input wire logic lock_req,
	input wire logic closed_a,
	input wire logic closed_b,
	input wire logic flip_a,
	input wire logic flip_b,
	output logic sol_in,
	output logic fb_a,
	output logic fb_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// The solenoid level that means lock depends on the variant.
	assign sol_in = pwr_lock ? lock_req : !lock_req;
	// A flipped read-back stands for stray voltage while off or a failed test while on.
	assign fb_a = closed_a ^ flip_a;
	assign fb_b = closed_b ^ flip_b;
endmodule

// [test_interlock_diag_supervisor.sv]
// Self-checking testbench for the interlock supervisor.
`include "interlock_defines.svh"
module test_interlock_diag_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	localparam int WT = 20;
	localparam int BURST = (`FLASH_ON_MS + `FLASH_OFF_MS) * TK;
	localparam int PAUSE = `FLASH_PAUSE_MS * TK;
	logic mclk = 1'h0, rst_b = 1'h0, act_det = 1'h0, act_margin = 1'h0, lock_tgt = 1'h0;
	logic xwire = 1'h0, temp_high = 1'h0, act_bad = 1'h0, tgt_bad = 1'h0, int_err = 1'h0;
	logic pwr_lock = 1'h0, lock_req = 1'h0, flip_a = 1'h0, flip_b = 1'h0;
	logic avs_read = 1'h0, avs_write = 1'h0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, closed_a, closed_b, locked_a, locked_b, diag, green, red, yellow;
	logic sol_in, fb_a, fb_b;
	int failures = 0;
	int samples_checked = 0;
	always #4 mclk = ~mclk;
	interlock_diag_supervisor #(.TICK_CYCLES(TK), .WARN_TICKS(WT)) interlock_diag_supervisor_inst (
		.MCLK(mclk), .RST_B(rst_b), .ACT_DET(act_det), .ACT_MARGIN(act_margin),
		.LOCK_TGT(lock_tgt), .SOL_IN(sol_in), .FB_CLOSED_A(fb_a), .FB_CLOSED_B(fb_b),
		.XWIRE_DET(xwire), .TEMP_HIGH(temp_high), .ACT_BAD(act_bad), .TGT_COMB_BAD(tgt_bad),
		.INT_ERR(int_err), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.CLOSED_OUT_A(closed_a), .CLOSED_OUT_B(closed_b), .LOCKED_OUT_A(locked_a),
		.LOCKED_OUT_B(locked_b), .DIAG_OUT(diag), .LED_GREEN(green), .LED_RED(red),
		.LED_YELLOW(yellow));
	plc_side_model plc_side_model_inst (.pwr_lock(pwr_lock), .lock_req(lock_req),
		.closed_a(closed_a), .closed_b(closed_b), .flip_a(flip_a), .flip_b(flip_b),
		.sol_in(sol_in), .fb_a(fb_a), .fb_b(fb_b));
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// The request is held until waitrequest is sampled low, then released.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (n >= 50) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0000_0000, 4'hf, q);
		check(q & m, e);
	endtask
	task automatic outs(input logic [4:0] e);
		check({27'h000_0000, closed_a, closed_b, locked_a, locked_b, diag}, {27'h000_0000, e});
	endtask
	task automatic watch(input int n, output int rises, output int toggles);
		logic pr, py;
		rises = 0;
		toggles = 0;
		pr = red;
		py = yellow;
		repeat (n) begin
			@(posedge mclk);
			if (red === 1'h1 && pr === 1'h0) rises++;
			if (yellow !== py) toggles++;
			pr = red;
			py = yellow;
		end
	endtask
	task automatic set_cause(input int k, input logic v);
		@(posedge mclk);
		case (k)
			1: flip_a <= v;
			2: flip_b <= v;
			3: xwire <= v;
			4: temp_high <= v;
			5: act_bad <= v;
			6: tgt_bad <= v;
			default: int_err <= v;
		endcase
	endtask
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		int r, y, k;
		logic [31:0] q;
		cyc(10);
		rst_b <= 1'h1;
		cyc(2);
		outs(5'h02);
		check({31'h0000_0000, green}, 32'h0000_0001);
		bus(1'h1, `REG_CTRL_ADDR, 32'h0000_0001, 4'h0, q);
		rdchk(`REG_CTRL_ADDR, 32'hffff_ffff, 32'h0000_0000);
		bus(1'h1, 4'hc, 32'hffff_ffff, 4'hf, q);
		rdchk(4'hc, 32'hffff_ffff, 32'h0000_0000);
		rdchk(`REG_STATUS_ADDR, 32'h0000_001f, 32'h0000_0000);
		$display("test reset and registers done");
		for (int v = 0; v < 2; v++) begin
			pwr_lock <= v[0];
			bus(1'h1, `REG_CTRL_ADDR, {31'h0000_0000, v[0]}, 4'h1, q);
			rdchk(`REG_CTRL_ADDR, 32'h0000_0001, {31'h0000_0000, v[0]});
			lock_req <= 1'h0;
			lock_tgt <= 1'h1;
			act_det <= 1'h1;
			cyc(10);
			outs(5'h1a);
			lock_req <= 1'h1;
			cyc(10);
			outs(5'h1d);
			watch(1400, r, y);
			check(y, 0);
			check({31'h0000_0000, yellow}, 32'h0000_0001);
			rdchk(`REG_STATUS_ADDR, 32'h0000_001f, 32'h0000_0013);
			act_margin <= 1'h1;
			watch(1400, r, y);
			check({31'h0000_0000, (y > 0)}, 32'h0000_0001);
			act_margin <= 1'h0;
			lock_req <= 1'h0;
			cyc(10);
			outs(5'h1a);
			lock_req <= 1'h1;
			cyc(10);
			outs(5'h1d);
			lock_tgt <= 1'h0;
			cyc(10);
			outs(5'h1a);
			lock_tgt <= 1'h1;
			cyc(10);
		end
		$display("test enabling paths done");
		for (k = 1; k <= 7; k++) begin
			// The read-back check arms only once the closed pair has been steady.
			cyc(`FB_SETTLE_NS / `MCLK_PERIOD_NS + 20);
			set_cause(k, 1'h1);
			cyc(12);
			if (k < 5) begin
				outs(5'h1c);
				rdchk(`REG_STATUS_ADDR, 32'h0000_0004, 32'h0000_0004);
				rdchk(`REG_FAULT_ADDR, 32'h0000_0007, k);
				set_cause(k, 1'h0);
				cyc(12);
				rdchk(`REG_STATUS_ADDR, 32'h0000_001c, 32'h0000_0010);
				set_cause(k, 1'h1);
				cyc((WT + 2) * TK + 12);
			end
			outs(5'h02);
			rdchk(`REG_STATUS_ADDR, 32'h0000_0008, 32'h0000_0008);
			rdchk(`REG_FAULT_ADDR, 32'h0000_0070, k * 16);
			watch(k < 7 ? k * BURST + PAUSE : 100, r, y);
			check(r, k < 7 ? k : 0);
			if (k == 7) check({31'h0000_0000, red}, 32'h0000_0001);
			set_cause(k, 1'h0);
			cyc(12);
			outs(5'h02);
			act_det <= 1'h0;
			cyc(12);
			act_det <= 1'h1;
			cyc(12);
			outs(5'h1d);
		end
		$display("test fault codes done");
		print_verdict();
	end
endmodule
